// [rsso_host_model.sv]
// Behavioural processor core and debug host on the register side.
// Assumes a single core_clk; requests change on the falling edge.
`timescale 1ns/1ps
`default_nettype none

module rsso_host_model (
   input wire logic core_clk,
   output var logic sel_cause_flags,
   output var logic sel_debug_force,
   output var logic sel_options,
   output var logic reg_write,
   output var logic [7:0] reg_wdata,
   output var logic debug_access
);
   // ****************************************
   // Idle bus at time zero
   // ****************************************
   initial begin
      sel_cause_flags = 1'b0;
      sel_debug_force = 1'b0;
      sel_options = 1'b0;
      reg_write = 1'b0;
      reg_wdata = 8'h5a;
      debug_access = 1'b0;
   end

   // One-cycle write; which: 0 status, 1 debug force, 2 options
   task automatic wr(input logic [1:0] which, input logic [7:0] data, input logic dbg);
      @(negedge core_clk);
      sel_cause_flags = (which == 2'h0);
      sel_debug_force = (which == 2'h1);
      sel_options = (which == 2'h2);
      reg_write = 1'b1;
      reg_wdata = data;
      debug_access = dbg;
      // Mode pin is not modelled: host would hold it high for user mode
      @(negedge core_clk);
      sel_cause_flags = 1'b0;
      sel_debug_force = 1'b0;
      sel_options = 1'b0;
      reg_write = 1'b0;
      debug_access = 1'b0;
      // Released data is inverted so stale values never look valid
      reg_wdata = ~data;
   endtask : wr
endmodule : rsso_host_model

`default_nettype wire

// [rsso_pkg.sv]
// Constants and state types for the reset source and system options block.
// Assumes a single bus clock domain and an active-low power-on reset.
package rsso_pkg;

   // ****************************************
   // Reset-cause flag positions
   // ****************************************
   localparam int FLAG_POWER_ON = 7;      // Power-on detect
   localparam int FLAG_PIN = 6;           // External reset pin
   localparam int FLAG_WATCHDOG = 5;      // Watchdog timeout
   localparam int FLAG_ILL_OPCODE = 4;    // Illegal opcode
   localparam int FLAG_ILL_ADDRESS = 3;   // Illegal address
   localparam int FLAG_LOW_VOLTAGE = 1;   // Low-voltage trip or power-on

   // Flags after power-on: power-on plus low voltage
   localparam logic [7:0] FLAGS_POR = 8'h82;
   // Flags after a debug-forced reset: none set
   localparam logic [7:0] FLAGS_NONE = 8'h00;
   // Debug force-reset register always reads this
   localparam logic [7:0] DEBUG_READ_VALUE = 8'h00;

   // ****************************************
   // Option register layout
   // ****************************************
   localparam int OPT_WATCHDOG_EN = 7;    // Watchdog enable
   localparam int OPT_LONG_TIMEOUT = 6;   // Long watchdog timeout
   localparam int OPT_STOP_EN = 5;        // Stop mode enable
   localparam int OPT_DEBUG_PIN = 1;      // Shared pin as debug/mode pin
   localparam int OPT_RESET_PIN = 0;      // Shared pin as reset input
   localparam int DEBUG_FORCE_BIT = 0;    // Force bit in debug register

   // Implemented option bits; others read zero
   localparam logic [7:0] OPT_MASK = 8'he3;
   // Option value after reset
   localparam logic [7:0] OPT_RESET = 8'hc3;

   // ****************************************
   // Timing
   // ****************************************
   localparam logic [7:0] RESET_HOLD_CYCLES = 8'h04;  // Internal reset stretch
   localparam logic [7:0] HOLD_ZERO = 8'h00;
   localparam logic [7:0] HOLD_STEP = 8'h01;

   // Sequencer phase
   typedef enum logic [0:0] {
      PH_RUN = 1'b0,    // Normal operation
      PH_HOLD = 1'b1    // Internal reset asserted
   } rsso_phase_t;

   // Whole block state
   typedef struct packed {
      rsso_phase_t phase;     // Run or in reset
      logic [7:0] hold_cnt;   // Remaining reset cycles
      logic [7:0] flags;      // Reset-cause flags
      logic [7:0] options;    // Write-once options
      logic opt_locked;       // First option write seen
      logic wd_restart;       // Watchdog restart pulse
   } rsso_state_t;

   // State at power-on
   localparam rsso_state_t STATE_POR = '{
      phase: PH_HOLD,
      hold_cnt: RESET_HOLD_CYCLES,
      flags: FLAGS_POR,
      options: OPT_RESET,
      opt_locked: 1'b0,
      wd_restart: 1'b0
   };

endpackage : rsso_pkg

// [rsso_top.sv]
// Reset-cause recorder, debug forced reset and write-once system options.
// Assumes all inputs synchronous to core_clk; rst_n is the power-on reset.
// Functional notes
// - Status flags at bits 7,6,5,4,3,1; rest zero
// - Debug-forced reset leaves all flags clear
// - Status write restarts watchdog, flags unchanged
// - Power-on sets power-on and low-voltage flags
// - Low-voltage reset sets its flag, keeps power-on
// - Other resets set flags of active sources
// - Reset pin low level sets pin flag
// - No watchdog reset while watchdog disabled
// - Illegal opcodes, and stop or background entry while not enabled, raise opcode reset
// - Unimplemented address access raises address reset
// - Debug register reads zero; only debug writes act
// - Debug write of one forces full reset
// - Options accept first write after reset only
// - Options bit 7 enables the watchdog
// - Options bit 6 selects long watchdog timeout
// - Stop disabled turns stop into opcode reset
// - Options bit 1 selects debug pin function
// - Options bit 0 selects reset pin function
`timescale 1ns/1ps
`default_nettype none

module rsso_top (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic sel_cause_flags,
   input wire logic sel_debug_force,
   input wire logic sel_options,
   input wire logic reg_write,
   input wire logic [7:0] reg_wdata,
   input wire logic debug_access,
   input wire logic reset_pin_n,
   input wire logic watchdog_timeout,
   input wire logic unimplemented_opcode,
   input wire logic stop_executed,
   input wire logic enter_background_instruction,
   input wire logic background_mode_enable,
   input wire logic illegal_address_access,
   input wire logic low_voltage_trip,
   input wire logic low_voltage_reset_enable,
   output logic [7:0] reset_cause_flags,
   output logic [7:0] debug_forced_reset,
   output logic [7:0] system_options_once,
   output logic mcu_reset,
   output logic watchdog_restart,
   output logic watchdog_enable,
   output logic watchdog_long_timeout,
   output logic stop_mode_enable,
   output logic debug_pin_enable,
   output logic reset_pin_enable,
   output logic reset_pin_pullup_en
);

   // ****************************************
   // State
   // ****************************************
   rsso_pkg::rsso_state_t state_reg;   // Registered state
   rsso_pkg::rsso_state_t state_next;  // Next state

   logic running;        // Sequencer in normal operation
   logic src_lvd;        // Enabled low-voltage trip
   logic src_pin;        // Reset pin held low
   logic src_wdog;       // Enabled watchdog timeout
   logic src_illegal_opcode_flag;       // Illegal opcode of any kind
   logic src_illegal_address_flag;       // Illegal address
   logic src_force;      // Debug host forced reset
   logic any_cause;      // Pin, watchdog, opcode or address source active
   logic wr_flags;       // Write to the status address
   logic wr_options;     // Write to the options register
   logic quiet;          // No reset source of any kind this cycle

   // ****************************************
   // Reset sources
   // ****************************************
   assign running = (state_reg.phase == rsso_pkg::PH_RUN);
   // Low-voltage resets only when enabled
   assign src_lvd = low_voltage_trip & low_voltage_reset_enable;
   // Pin only counts while it is configured as reset input
   assign src_pin = ~reset_pin_n & state_reg.options[rsso_pkg::OPT_RESET_PIN];
   // Timeout is blocked entirely while disabled
   assign src_wdog = watchdog_timeout & state_reg.options[rsso_pkg::OPT_WATCHDOG_EN];
   // Stop and background entry become illegal when not enabled
   assign src_illegal_opcode_flag = unimplemented_opcode
                   | (stop_executed & ~state_reg.options[rsso_pkg::OPT_STOP_EN])
                   | (enter_background_instruction & ~background_mode_enable);
   assign src_illegal_address_flag = illegal_address_access;
   // Program writes cannot force; only background commands can
   assign src_force = reg_write & sel_debug_force & debug_access
                    & reg_wdata[rsso_pkg::DEBUG_FORCE_BIT];
   assign any_cause = src_pin | src_wdog | src_illegal_opcode_flag | src_illegal_address_flag;
   assign wr_flags = reg_write & sel_cause_flags;
   assign wr_options = reg_write & sel_options;
   // Shared by the assertions that look at plain register traffic
   assign quiet = ~src_lvd & ~any_cause & ~src_force;

   // ****************************************
   // Next-state logic
   // ****************************************
   always_comb begin
      state_next = state_reg;
      state_next.wd_restart = 1'b0;
      case (state_reg.phase)
         rsso_pkg::PH_HOLD: begin
            // Stretch the internal reset, then release
            if (state_reg.hold_cnt == rsso_pkg::HOLD_ZERO) begin
               state_next.phase = rsso_pkg::PH_RUN;
            end else begin
               state_next.hold_cnt = state_reg.hold_cnt - rsso_pkg::HOLD_STEP;
            end
         end
         rsso_pkg::PH_RUN: begin
            if (src_lvd || any_cause || src_force) begin
               // Common reset entry; option lock reopens
               state_next.phase = rsso_pkg::PH_HOLD;
               state_next.hold_cnt = rsso_pkg::RESET_HOLD_CYCLES;
               state_next.opt_locked = 1'b0;
               if (src_lvd) begin
                  // Low voltage wins; power-on flag kept
                  state_next.flags = rsso_pkg::FLAGS_NONE;
                  state_next.flags[rsso_pkg::FLAG_POWER_ON] =
                     state_reg.flags[rsso_pkg::FLAG_POWER_ON];
                  state_next.flags[rsso_pkg::FLAG_LOW_VOLTAGE] = 1'b1;
                  // Reset pin function restored as well
                  state_next.options = rsso_pkg::OPT_RESET;
               end else begin
                  // Each active source sets its flag; forced alone leaves none
                  state_next.flags = rsso_pkg::FLAGS_NONE;
                  state_next.flags[rsso_pkg::FLAG_PIN] = src_pin;
                  state_next.flags[rsso_pkg::FLAG_WATCHDOG] = src_wdog;
                  state_next.flags[rsso_pkg::FLAG_ILL_OPCODE] = src_illegal_opcode_flag;
                  state_next.flags[rsso_pkg::FLAG_ILL_ADDRESS] = src_illegal_address_flag;
                  // Reset pin choice survives non-power resets
                  state_next.options = rsso_pkg::OPT_RESET;
                  state_next.options[rsso_pkg::OPT_RESET_PIN] =
                     state_reg.options[rsso_pkg::OPT_RESET_PIN];
               end
            end else begin
               // Any write to status address only kicks the watchdog
               if (wr_flags) begin
                  state_next.wd_restart = 1'b1;
               end
               // Only the first options write takes effect
               if (wr_options && !state_reg.opt_locked) begin
                  state_next.options = reg_wdata & rsso_pkg::OPT_MASK;
                  state_next.opt_locked = 1'b1;
               end
            end
         end
         default: begin
            state_next = rsso_pkg::STATE_POR;
         end
      endcase
   end

   // ****************************************
   // State register
   // ****************************************
   // Power-on reset loads the power-on flags and options
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= rsso_pkg::STATE_POR;
      end else begin
         state_reg <= state_next;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign reset_cause_flags = state_reg.flags;
   assign debug_forced_reset = rsso_pkg::DEBUG_READ_VALUE;
   assign system_options_once = state_reg.options;
   assign mcu_reset = (state_reg.phase == rsso_pkg::PH_HOLD);
   assign watchdog_restart = state_reg.wd_restart;
   assign watchdog_enable = state_reg.options[rsso_pkg::OPT_WATCHDOG_EN];
   // Period also depends on the watchdog clock source chosen elsewhere
   assign watchdog_long_timeout = state_reg.options[rsso_pkg::OPT_LONG_TIMEOUT];
   assign stop_mode_enable = state_reg.options[rsso_pkg::OPT_STOP_EN];
   assign debug_pin_enable = state_reg.options[rsso_pkg::OPT_DEBUG_PIN];
   assign reset_pin_enable = state_reg.options[rsso_pkg::OPT_RESET_PIN];
   // Pull-up follows the reset-input function
   assign reset_pin_pullup_en = state_reg.options[rsso_pkg::OPT_RESET_PIN];

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   a_unused_bits_zero:
      assert property (!reset_cause_flags[2] && !reset_cause_flags[0])
      else $error("Unused status bits not zero");

   a_restart_pulse:
      assert property (running && wr_flags && !src_lvd && !any_cause && !src_force
                       |=> watchdog_restart && $stable(reset_cause_flags)
                           ##1 !watchdog_restart)
      else $error("Status write did not give one restart pulse");

   a_lvd_entry:
      assert property (running && src_lvd
                       |=> reset_cause_flags[1] && reset_cause_flags[6:3] == 4'h0
                           && reset_cause_flags[7] == $past(reset_cause_flags[7]))
      else $error("Low-voltage entry flags wrong");

   a_force_clear:
      assert property (running && src_force && !src_lvd && !any_cause
                       |=> reset_cause_flags == 8'h00 && mcu_reset)
      else $error("Forced reset left flags set");

   a_wdog_gated:
      assert property (running && !watchdog_enable |=> !reset_cause_flags[5]
                       || $stable(reset_cause_flags))
      else $error("Watchdog flag set while disabled");

   a_pin_flag:
      assert property (running && src_pin && !src_lvd |=> reset_cause_flags[6] && mcu_reset)
      else $error("Pin reset not flagged");

   a_stop_illegal_opcode_flag:
      assert property (running && stop_executed && !stop_mode_enable && !src_lvd
                       |=> reset_cause_flags[4])
      else $error("Disabled stop did not raise opcode reset");

   a_illegal_address_flag_flag:
      assert property (running && illegal_address_access && !src_lvd |=> reset_cause_flags[3])
      else $error("Illegal address not flagged");

   a_options_once:
      assert property (running && state_reg.opt_locked && !src_lvd && !any_cause && !src_force
                       |=> $stable(system_options_once))
      else $error("Locked options changed");

   a_hold_length:
      assert property ($rose(mcu_reset) |-> mcu_reset[*5] ##1 !mcu_reset)
      else $error("Internal reset length wrong");

   a_debug_pin_default:
      assert property ($fell(mcu_reset) |-> debug_pin_enable && !state_reg.opt_locked)
      else $error("Debug pin function not restored");

   // Power-on release shows power-on and low-voltage flags, reset held
   a_por_flags:
      assert property ($rose(rst_n) |-> reset_cause_flags == rsso_pkg::FLAGS_POR && mcu_reset)
      else $error("Power-on flags wrong after release");

   // Other sources set exactly their own flags and nothing else
   a_source_flags:
      assert property (running && !src_lvd && any_cause
                       |=> reset_cause_flags == {1'b0, $past(src_pin), $past(src_wdog),
                                                 $past(src_illegal_opcode_flag), $past(src_illegal_address_flag), 3'h0})
      else $error("Reset source flags wrong");

   // Enabled watchdog timeout gives a watchdog reset
   a_wdog_flag:
      assert property (running && src_wdog && !src_lvd
                       |=> reset_cause_flags[rsso_pkg::FLAG_WATCHDOG] && mcu_reset)
      else $error("Watchdog timeout not flagged");

   // Disabled background entry counts as an illegal opcode
   a_enter_background_instruction_illegal_opcode_flag:
      assert property (running && enter_background_instruction && !background_mode_enable
                       && !src_lvd |=> reset_cause_flags[rsso_pkg::FLAG_ILL_OPCODE])
      else $error("Disabled background entry not flagged");

   // A program write to the force register must not reset the part
   a_user_force_ignored:
      assert property (running && reg_write && sel_debug_force && !debug_access && quiet
                       |=> !mcu_reset)
      else $error("Program write forced a reset");

   // No source, no reset
   a_no_false_reset:
      assert property (running && quiet |=> !mcu_reset)
      else $error("Reset without a source");

   // Flags freeze while the internal reset is held
   a_flags_frozen:
      assert property (!running |=> $stable(reset_cause_flags))
      else $error("Flags changed during internal reset");

   // Writes during the internal reset never lock the options
   a_hold_unlocked:
      assert property (!running |=> !state_reg.opt_locked)
      else $error("Options locked during internal reset");

   // The first options write after reset is taken as written
   a_options_first:
      assert property (running && wr_options && !state_reg.opt_locked && quiet
                       |=> system_options_once == ($past(reg_wdata) & rsso_pkg::OPT_MASK))
      else $error("First options write not taken");

   // Low-voltage reset restores every option, reset pin included
   a_lvd_options:
      assert property (running && src_lvd |=> system_options_once == rsso_pkg::OPT_RESET)
      else $error("Low-voltage reset left options changed");

   // Other resets keep the reset-pin choice and restore the debug pin
   a_pin_choice_kept:
      assert property (running && !src_lvd && (any_cause || src_force)
                       |=> reset_pin_enable == $past(reset_pin_enable) && debug_pin_enable)
      else $error("Pin choices wrong after reset");

   // A restart pulse only follows a status write while running
   a_restart_source:
      assert property (watchdog_restart |-> $past(running) && $past(wr_flags))
      else $error("Restart pulse without a status write");

   // Reset stretch counter never runs past its load value
   a_hold_bound:
      assert property (state_reg.hold_cnt <= rsso_pkg::RESET_HOLD_CYCLES)
      else $error("Reset stretch counter out of range");

   // ****************************************
   // Cover points
   // ****************************************
   // Main scenarios that every regression run should reach

   // Debug host forces a full reset
   c_forced_reset:
      cover property (running && src_force ##1 mcu_reset);

   // First options write after a reset
   c_options_write:
      cover property (running && wr_options && !state_reg.opt_locked);

   // Enabled watchdog timeout
   c_watchdog_reset:
      cover property (running && src_wdog ##1 reset_cause_flags[5]);

   // Low-voltage reset while enabled
   c_low_voltage_reset:
      cover property (running && src_lvd ##1 mcu_reset);

   // Status write kicks the watchdog
   c_status_restart:
      cover property (running && wr_flags ##1 watchdog_restart);

endmodule : rsso_top

`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the reset source and system options block.
// Assumes rsso_pkg, rsso_top and rsso_host_model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [6:0] src = 7'h00; // Sources: pin,wdog,opc,stop,enter_background_instruction,addr,lv
   logic bme = 1'b0;
   logic lvre = 1'b1;
   logic sel_cause_flags, sel_debug_force, sel_options, reg_write, debug_access;
   logic [7:0] reg_wdata, reset_cause_flags, debug_forced_reset, system_options_once;
   logic mcu_reset, watchdog_restart, watchdog_enable, watchdog_long_timeout;
   logic stop_mode_enable, debug_pin_enable, reset_pin_enable, reset_pin_pullup_en;
   int miscompares = 0;
   int checks_done = 0;
   integer seed = 96793;
   logic [7:0] opt_val;
   logic [6:0] rnd;
   logic [7:0] exp_f, exp_o, old_f;
   logic [6:0] src_tab [9] = '{7'h40, 7'h01, 7'h02, 7'h04, 7'h08, 7'h10, 7'h20, 7'h03, 7'h40};
   logic [7:0] exp_tab [9] = '{8'h82, 8'h40, 8'h20, 8'h10, 8'h10, 8'h10, 8'h08, 8'h60, 8'h02};

   // ****************************************
   // Clock and instances
   // ****************************************
   always #50 core_clk = ~core_clk;

   rsso_host_model i_rsso_host_model (.core_clk(core_clk), .sel_cause_flags(sel_cause_flags),
      .sel_debug_force(sel_debug_force), .sel_options(sel_options), .reg_write(reg_write),
      .reg_wdata(reg_wdata), .debug_access(debug_access));

   rsso_top i_rsso_top (.core_clk(core_clk), .rst_n(rst_n), .sel_cause_flags(sel_cause_flags),
      .sel_debug_force(sel_debug_force), .sel_options(sel_options), .reg_write(reg_write),
      .reg_wdata(reg_wdata), .debug_access(debug_access), .reset_pin_n(~src[0]),
      .watchdog_timeout(src[1]), .unimplemented_opcode(src[2]), .stop_executed(src[3]),
      .enter_background_instruction(src[4]), .background_mode_enable(bme),
      .illegal_address_access(src[5]), .low_voltage_trip(src[6]),
      .low_voltage_reset_enable(lvre), .reset_cause_flags(reset_cause_flags),
      .debug_forced_reset(debug_forced_reset), .system_options_once(system_options_once),
      .mcu_reset(mcu_reset), .watchdog_restart(watchdog_restart),
      .watchdog_enable(watchdog_enable), .watchdog_long_timeout(watchdog_long_timeout),
      .stop_mode_enable(stop_mode_enable), .debug_pin_enable(debug_pin_enable),
      .reset_pin_enable(reset_pin_enable), .reset_pin_pullup_en(reset_pin_pullup_en));

   // ****************************************
   // Checking helpers
   // ****************************************
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // Expected flags for one source pulse; zero means no reset expected
   function automatic logic [7:0] calc_flags(input logic [6:0] s, input logic [7:0] old,
                                             input logic [7:0] opt, input logic bm,
                                             input logic lvr);
      logic [7:0] f;
      f = 8'h00;
      if (s[6] && lvr) begin
         // Low voltage wins and keeps the power-on flag
         f[7] = old[7];
         f[1] = 1'b1;
      end else begin
         f[6] = s[0] & opt[0];
         f[5] = s[1] & opt[7];
         f[4] = s[2] | (s[3] & ~opt[5]) | (s[4] & ~bm);
         f[3] = s[5];
      end
      return f;
   endfunction : calc_flags

   // Counts reset cycles; exp_n of zero skips the length check
   task automatic hold_count(input logic [7:0] exp_n, input logic [7:0] exp_flags,
                             input logic [7:0] exp_opts);
      int n;
      n = 0;
      while (mcu_reset === 1'b1 && n < 20) begin
         n++;
         @(negedge core_clk);
      end
      if (n == 20) begin
         // Reset never released: count it and end the run
         miscompares++;
         $display("wrong value at %0t: internal reset never released", $time);
         print_verdict();
      end else begin
         if (exp_n != 8'h00) chk(8'(n), exp_n);
         chk(reset_cause_flags, exp_flags);
         chk(system_options_once, exp_opts);
      end
   endtask : hold_count

   // One-cycle pulse on the chosen sources
   task automatic fire(input logic [6:0] s);
      @(negedge core_clk);
      src = s;
      @(negedge core_clk);
      src = 7'h00;
   endtask : fire

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (10) @(negedge core_clk);
      chk(reset_cause_flags, 8'h82);
      chk(8'(reset_pin_pullup_en), 8'h01);
      rst_n = 1'b1;
      hold_count(8'h05, 8'h82, 8'hc3);
      $display("test power-on done");
      // Every source, then low voltage again once the power-on flag is gone
      for (int i = 0; i < 9; i++) begin
         fire(src_tab[i]);
         hold_count(8'h05, exp_tab[i], 8'hc3);
      end
      $display("test reset sources done");
      // Status write: restart pulse, flags kept
      i_rsso_host_model.wr(2'h0, 8'($random(seed)), 1'b0);
      chk(8'(watchdog_restart), 8'h01);
      @(negedge core_clk);
      chk(8'(watchdog_restart), 8'h00);
      chk(reset_cause_flags, 8'h02);
      // User write to the force register does nothing
      i_rsso_host_model.wr(2'h1, 8'h01, 1'b0);
      chk(8'(mcu_reset), 8'h00);
      chk(debug_forced_reset, 8'h00);
      i_rsso_host_model.wr(2'h1, 8'h01, 1'b1);
      hold_count(8'h05, 8'h00, 8'hc3);
      $display("test restart and force done");
      // Options: start-up write taken, second ignored
      opt_val = 8'($random(seed));
      opt_val[7] = 1'b0;
      opt_val[5] = 1'b1;
      i_rsso_host_model.wr(2'h2, opt_val, 1'b0);
      chk(system_options_once, opt_val & 8'he3);
      chk(8'(watchdog_long_timeout), 8'(opt_val[6]));
      chk(8'(debug_pin_enable), 8'(opt_val[1]));
      chk(8'(reset_pin_enable), 8'(opt_val[0]));
      chk(8'(reset_pin_pullup_en), 8'(opt_val[0]));
      i_rsso_host_model.wr(2'h2, ~opt_val, 1'b0);
      chk(system_options_once, opt_val & 8'he3);
      chk(8'(watchdog_enable), 8'h00);
      chk(8'(stop_mode_enable), 8'h01);
      // Disabled watchdog, allowed stop and allowed background entry
      bme = 1'b1;
      fire(7'h1a);
      chk(8'(mcu_reset), 8'h00);
      @(negedge core_clk);
      chk(8'(mcu_reset), 8'h00);
      $display("test options done");
      // Random source mixes with random enables, low-voltage enable included
      for (int k = 0; k < 16; k++) begin
         rnd = 7'($random(seed));
         bme = 1'($random(seed));
         lvre = 1'($random(seed));
         old_f = reset_cause_flags;
         exp_f = calc_flags(rnd, old_f, system_options_once, bme, lvre);
         exp_o = (rnd[6] && lvre) ? 8'hc3 : (8'hc2 | {7'h00, system_options_once[0]});
         fire(rnd);
         if (exp_f != 8'h00) begin
            hold_count(8'h05, exp_f, exp_o);
         end else begin
            chk(8'(mcu_reset), 8'h00);
            chk(reset_cause_flags, old_f);
         end
      end
      lvre = 1'b1;
      $display("test random sources done");
      // Power-on reset in mid-run restores flags and options
      rst_n = 1'b0;
      repeat (2) @(negedge core_clk);
      chk(reset_cause_flags, 8'h82);
      chk(8'(mcu_reset), 8'h01);
      rst_n = 1'b1;
      hold_count(8'h05, 8'h82, 8'hc3);
      $display("test mid-run reset done");
      print_verdict();
   end
endmodule : tb_top

`default_nettype wire
